// ### src/fdx_pkg.sv
// Constants shared by the depth-expansion chain and its stage buffers.
// Assumes a single 50 MHz clock that also serves as the transfer clock.
package fdx_pkg;

	// ----------------------------------------------------------------
	// Chain shape
	// ----------------------------------------------------------------
	localparam int DATA_W = 18;
	localparam int STAGE_DEPTH = 8;
	localparam int NUM_STAGES = 2;

	// ----------------------------------------------------------------
	// Per-stage latencies in clock cycles
	// ----------------------------------------------------------------
	localparam int MID_FILL_LAT = 4;
	localparam int LAST_FILL_LAT = 3;
	localparam int MID_FREE_LAT = 3;
	localparam int FIRST_FREE_LAT = 2;

	// ----------------------------------------------------------------
	// Mode capture
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FDX_ST_CAPT = 2'h0,
		FDX_ST_RUN = 2'h1,
		FDX_ST_HOLD = 2'h3
	} fdx_state_t;

	localparam fdx_state_t STATE_RST = FDX_ST_CAPT;
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam logic [1:0] CAPT_CNT_RST = 2'h0;
	// Edges to wait after release before the strap is trusted
	localparam logic [1:0] CAPT_WAIT = 2'h2;

endpackage

// ### src/fdx_stream_if.sv
// Valid/ready stream joining two neighbouring stages of the chain.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface fdx_stream_if #(parameter int WIDTH = 18);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### src/fdx_fifo.sv
// One fall-through stage of the chain: a small buffer with fixed fill
// and free latencies. Assumes latencies of at least two cycles.
`timescale 1ns/10ps
module fdx_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8,
	parameter int FILL_LAT = 4,
	parameter int FREE_LAT = 3
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	fdx_stream_if.snk wr_if,
	fdx_stream_if.src rd_if
);
	import fdx_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || FILL_LAT < 2 || FREE_LAT < 2) begin : g_bad_cfg
		$error("fdx_fifo: depth must be a power of two, latencies >= 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] data_ff;
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_rd_ptr;
	logic [CW-1:0] used_ff, avail_ff;
	logic [FILL_LAT-1:0] fill_pipe_ff;
	logic [FREE_LAT-1:0] free_pipe_ff;
	logic wr_fire, rd_fire, fill_arrive, free_arrive;

	// ----------------------------------------------------------------
	// Handshakes and flags
	// ----------------------------------------------------------------
	assign wr_fire = wr_if.valid && wr_if.ready;
	assign rd_fire = rd_if.valid && rd_if.ready;
	assign fill_arrive = fill_pipe_ff[FILL_LAT-1];
	assign free_arrive = free_pipe_ff[FREE_LAT-1];
	assign wr_if.ready = (used_ff != FULL_CNT);
	assign rd_if.valid = (avail_ff != '0);
	assign rd_if.data = data_ff;
	assign nxt_rd_ptr = rd_fire ? rd_ptr_ff + AW'(1) : rd_ptr_ff;

	// ----------------------------------------------------------------
	// Storage: memory words are never reset; the output register and pointers are
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (wr_fire)
			mem_ff[wr_ptr_ff] <= wr_if.data;
	end

	// Word becomes visible only after the fill delay, so the slot is
	// already written when the output register loads it
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			data_ff <= '0;
		else
			data_ff <= mem_ff[nxt_rd_ptr];
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (wr_fire)
				wr_ptr_ff <= wr_ptr_ff + AW'(1);
			rd_ptr_ff <= nxt_rd_ptr;
		end
	end

	// ----------------------------------------------------------------
	// Latency pipes: each word pays the delay once, in parallel with
	// its neighbours, so a stream flows one word per cycle
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fill_pipe_ff <= '0;
			free_pipe_ff <= '0;
		end else begin
			fill_pipe_ff <= {fill_pipe_ff[FILL_LAT-2:0], wr_fire};
			free_pipe_ff <= {free_pipe_ff[FREE_LAT-2:0], rd_fire};
		end
	end

	// Read side count of words ready to leave
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			avail_ff <= '0;
		else
			avail_ff <= avail_ff + CW'(fill_arrive) - CW'(rd_fire);
	end

	// Write side count of slots taken; a slot frees only after its delay
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			used_ff <= '0;
		else
			used_ff <= used_ff + CW'(wr_fire) - CW'(free_arrive);
	end

endmodule // fdx_fifo

// ### src/fdx_chain.sv
// Depth-expansion chain of fall-through stages behind two flag pins.
// Assumes producer and consumer run on ref_clk_i; the mode strap is async.
`timescale 1ns/10ps
module fdx_chain #(
	parameter int DATA_W = fdx_pkg::DATA_W,
	parameter int STAGE_DEPTH = fdx_pkg::STAGE_DEPTH,
	parameter int NUM_STAGES = fdx_pkg::NUM_STAGES
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic first_data_fall_through_i,
	input wire logic wr_en_n_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	output logic input_space_flag_n_o,
	input wire logic rd_en_n_i,
	output logic [DATA_W-1:0] rd_data_o,
	output logic out_valid_n_o,
	output logic mode_fault_o
);
	import fdx_pkg::*;

	if (NUM_STAGES < 1 || DATA_W < 1) begin : g_bad_cfg
		$error("fdx_chain: need at least one stage and one data bit");
	end

	// ----------------------------------------------------------------
	// Mode strap: synchronised, then caught once after reset release
	// ----------------------------------------------------------------
	logic [1:0] strap_sync_ff;
	fdx_state_t state_ff, nxt_state;
	logic run;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			strap_sync_ff <= SYNC_RST;
		else
			strap_sync_ff <= {strap_sync_ff[0], first_data_fall_through_i};
	end

	// Wait until the strap has crossed both stages before deciding
	logic [1:0] capt_cnt_ff;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			capt_cnt_ff <= CAPT_CNT_RST;
		else if (state_ff == FDX_ST_CAPT)
			capt_cnt_ff <= capt_cnt_ff + 2'h1;
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FDX_ST_CAPT: begin
				if (capt_cnt_ff == CAPT_WAIT)
					nxt_state = strap_sync_ff[1] ? FDX_ST_RUN : FDX_ST_HOLD;
			end
			FDX_ST_RUN: nxt_state = FDX_ST_RUN;
			FDX_ST_HOLD: nxt_state = FDX_ST_HOLD;
			default: nxt_state = FDX_ST_CAPT;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			state_ff <= STATE_RST;
		else
			state_ff <= nxt_state;
	end

	// Chaining only works in fall-through mode; otherwise the chain
	// refuses all traffic until the next reset
	assign run = (state_ff == FDX_ST_RUN);
	assign mode_fault_o = (state_ff == FDX_ST_HOLD);

	// ----------------------------------------------------------------
	// Stage chain
	// ----------------------------------------------------------------
	fdx_stream_if #(.WIDTH(DATA_W)) link [NUM_STAGES+1] ();

	assign link[0].valid = !wr_en_n_i && run;
	assign link[0].data = wr_data_i;
	assign input_space_flag_n_o = !(link[0].ready && run);

	assign link[NUM_STAGES].ready = !rd_en_n_i && run;
	assign out_valid_n_o = !link[NUM_STAGES].valid;
	assign rd_data_o = link[NUM_STAGES].data;

	// Each stage's output stream feeds the next stage's input directly:
	// write of stage k+1 follows valid of k, read of k follows space of k+1
	// A middle stage's share of the chain delay includes the hand-off edge
	// into its neighbour, which its own pipe does not see: one cycle less
	for (genvar k = 0; k < NUM_STAGES; k++) begin : g_stage
		localparam int FILL = (k == NUM_STAGES - 1) ? LAST_FILL_LAT : MID_FILL_LAT - 1;
		localparam int FREE = (k == 0) ? FIRST_FREE_LAT : MID_FREE_LAT - 1;

		fdx_fifo #(
			.WIDTH(DATA_W),
			.DEPTH(STAGE_DEPTH),
			.FILL_LAT(FILL),
			.FREE_LAT(FREE)
		) u_stage (
			.ref_clk_i(ref_clk_i),
			.arst_n_i(arst_n_i),
			.wr_if(link[k]),
			.rd_if(link[k+1])
		);
	end

endmodule // fdx_chain

// ### verif/fdx_chain_asserts.sv
// Checker on the chain's top ports: flag timing, word hold, capacity.
// Assumes one clock; attached to every fdx_chain by the bind below.
`timescale 1ns/10ps
module fdx_chain_asserts #(
	parameter int DATA_W = 18,
	parameter int STAGE_DEPTH = 8,
	parameter int NUM_STAGES = 2
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic wr_en_n_i,
	input wire logic input_space_flag_n_o,
	input wire logic rd_en_n_i,
	input wire logic [DATA_W-1:0] rd_data_o,
	input wire logic out_valid_n_o,
	input wire logic mode_fault_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic wr_t;
	logic rd_t;
	logic [7:0] cnt_ff;
	logic [7:0] age_ff;
	assign wr_t = !wr_en_n_i && !input_space_flag_n_o;
	assign rd_t = !rd_en_n_i && !out_valid_n_o;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) cnt_ff <= 8'h00;
		else cnt_ff <= cnt_ff + 8'(wr_t) - 8'(rd_t);
	end
	// Age saturates so long idle spans never wrap back to young
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) age_ff <= 8'h00;
		else age_ff <= wr_t ? 8'h00 : (age_ff == 8'hff ? age_ff : age_ff + 8'h01);
	end
	chk_fill_delay: assert property (wr_t && cnt_ff == 0 |-> ##1 out_valid_n_o [*7] ##1 !out_valid_n_o)
		else $error("fill delay off");
	chk_free_delay: assert property (rd_t && cnt_ff == 8'(NUM_STAGES * STAGE_DEPTH)
		|-> ##1 input_space_flag_n_o [*5] ##1 !input_space_flag_n_o)
		else $error("free delay off");
	chk_valid_hold: assert property (!out_valid_n_o && rd_en_n_i |=> !out_valid_n_o)
		else $error("valid dropped");
	chk_word_hold: assert property (!out_valid_n_o && rd_en_n_i |=> $stable(rd_data_o))
		else $error("word changed");
	chk_next_ready: assert property (rd_t && cnt_ff > 8'h01 && age_ff > 8'h0c |=> !out_valid_n_o)
		else $error("late next word");
	chk_space_hold: assert property (!input_space_flag_n_o && wr_en_n_i |=> !input_space_flag_n_o)
		else $error("space dropped");
	chk_full_refuse: assert property (cnt_ff == 8'(NUM_STAGES * STAGE_DEPTH) |-> input_space_flag_n_o)
		else $error("space when full");
	chk_fault_idle: assert property (mode_fault_o |-> input_space_flag_n_o && out_valid_n_o)
		else $error("fault not idle");
	cover property (wr_t && cnt_ff == 0);
	cover property (rd_t && cnt_ff == 8'(NUM_STAGES * STAGE_DEPTH));
	cover property (mode_fault_o);
endmodule // fdx_chain_asserts

bind fdx_chain fdx_chain_asserts #(.DATA_W(DATA_W), .STAGE_DEPTH(STAGE_DEPTH),
	.NUM_STAGES(NUM_STAGES)) i_fdx_chain_asserts (.ref_clk_i, .arst_n_i, .wr_en_n_i,
	.input_space_flag_n_o, .rd_en_n_i, .rd_data_o, .out_valid_n_o, .mode_fault_o);

// ### verif/fdx_consumer.sv
// Consumer at the chain's far end: reads at a random rate when enabled.
// Assumes go_i and rate_i change at the falling edge.
`timescale 1ns/10ps
module fdx_consumer (
	input wire logic ref_clk_i,
	input wire logic go_i,
	input wire logic [7:0] rate_i,
	output logic rd_en_n_o
);
	logic coin_ff = 1'b0;
	always @(negedge ref_clk_i) coin_ff <= ($urandom_range(99) < rate_i);
	// Active-low read enable, held steady across the rising edge
	assign rd_en_n_o = !(go_i && coin_ff);
endmodule // fdx_consumer

// ### verif/fdx_chain_tb.sv
// Self-checking bench for the chain: latencies, capacity, order, fault.
// Assumes the consumer model on the read side and a 50 MHz clock.
`timescale 1ns/10ps
module fdx_chain_tb;
	import fdx_pkg::*;
	localparam int NS = 2;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic strap = 1'b1;
	logic wr_en_n_i = 1'b1;
	logic go = 1'b0;
	logic [7:0] rate = 8'h00;
	logic [DATA_W-1:0] wr_data_i = '0;
	logic rd_en_n_i, input_space_flag_n_o, out_valid_n_o, mode_fault_o;
	logic [DATA_W-1:0] rd_data_o;
	logic [DATA_W-1:0] exp_q[$];
	int mismatches = 0;
	int n_compared = 0;
	int k;
	fdx_chain #(.NUM_STAGES(NS)) i_fdx_chain (.ref_clk_i, .arst_n_i,
		.first_data_fall_through_i(strap), .wr_en_n_i, .wr_data_i, .input_space_flag_n_o,
		.rd_en_n_i, .rd_data_o, .out_valid_n_o, .mode_fault_o);
	fdx_consumer i_fdx_consumer (.ref_clk_i, .go_i(go), .rate_i(rate), .rd_en_n_o(rd_en_n_i));
	initial forever #10 ref_clk_i = ~ref_clk_i;
	// One clock for every stage: exact figures, no skew margin budgeted
	function automatic int fill_lat(int n); return (n - 1) * 4 + 3; endfunction
	function automatic int free_lat(int n); return (n - 1) * 3 + 2; endfunction
	task automatic check(bit ok, string msg);
		n_compared++;
		if (!ok) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic do_reset(logic s);
		strap = s;
		arst_n_i = 1'b0;
		exp_q = {};
		repeat (10) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
	endtask
	// Scoreboard sees pre-edge values, so order is fixed by the edge itself
	always @(posedge ref_clk_i) if (arst_n_i) begin
		if (!rd_en_n_i && !out_valid_n_o) begin
			check(exp_q.size() > 0 && rd_data_o === exp_q[0], "read word");
			if (exp_q.size() > 0) void'(exp_q.pop_front());
		end
		if (!wr_en_n_i && input_space_flag_n_o === 1'b0) exp_q.push_back(wr_data_i);
	end
	initial begin
		#100us;
		mismatches++;
		results();
	end
	initial begin
		k = $urandom(29951);
		do_reset(1'b0);
		wr_en_n_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		wr_en_n_i = 1'b1;
		check(mode_fault_o === 1'b1 && input_space_flag_n_o === 1'b1 && exp_q.size() == 0, "fault");
		do_reset(1'b1);
		check(mode_fault_o === 1'b0 && out_valid_n_o === 1'b1, "idle flags");
		wr_data_i = DATA_W'($urandom);
		wr_en_n_i = 1'b0;
		@(negedge ref_clk_i);
		wr_en_n_i = 1'b1;
		for (k = 0; out_valid_n_o !== 1'b0 && k < 30; k++) @(negedge ref_clk_i);
		check(k == fill_lat(NS) && rd_data_o === exp_q[0], "fill delay");
		rate = 8'd100;
		wr_en_n_i = 1'b0;
		repeat (40) begin
			wr_data_i = DATA_W'($urandom);
			@(negedge ref_clk_i);
		end
		wr_en_n_i = 1'b1;
		check(exp_q.size() == NS * STAGE_DEPTH && input_space_flag_n_o === 1'b1, "capacity");
		go = 1'b1;
		@(negedge ref_clk_i);
		go = 1'b0;
		for (k = 0; input_space_flag_n_o !== 1'b0 && k < 30; k++) @(negedge ref_clk_i);
		check(k == free_lat(NS), "free delay");
		rate = 8'd60;
		go = 1'b1;
		repeat (400) begin
			wr_en_n_i = 1'($urandom_range(1));
			wr_data_i = DATA_W'($urandom);
			@(negedge ref_clk_i);
		end
		wr_en_n_i = 1'b1;
		repeat (80) @(negedge ref_clk_i);
		check(exp_q.size() == 0 && out_valid_n_o === 1'b1, "drained");
		results();
	end
endmodule // fdx_chain_tb
